// file: srap_cfg.svh
`ifndef SRAP_CFG_SVH
`define SRAP_CFG_SVH

// Frame layout
`define SRAP_INSTR_LAST   4'hf
`define SRAP_BYTE_LAST    4'h7
`define SRAP_ADDR_W       13

// Port control register addresses
`define SRAP_ADDR_CFG     13'h0000
`define SRAP_ADDR_RBSEL   13'h0001
`define SRAP_ADDR_UPDATE  13'h000f

// Field positions
`define SRAP_BIT_LSB      6
`define SRAP_BIT_ASC      5
`define SRAP_BIT_FOUR     4
`define SRAP_BIT_RBSEL    5
`define SRAP_BIT_UPDATE   0

// Buffered register window
`define SRAP_MAP_BASE     13'h0010
`define SRAP_MAP_DEPTH    64
`define SRAP_MAP_AW       6

// Reset values
`define SRAP_RST_LSB      1'b0
`define SRAP_RST_ASC      1'b0
`define SRAP_RST_FOUR     1'b0
`define SRAP_RST_RBSEL    1'b0
`define SRAP_RST_BYTE     8'h00

`endif

// file: srap_pkg.sv
package srap_pkg;

	// Frame phase, one-hot
	typedef enum logic [1:0] {
		SRAP_INSTR = 2'b01,
		SRAP_DATA  = 2'b10
	} srap_phase_type;

	// Instruction word as received
	typedef struct packed {
		logic        rw;
		logic [1:0]  hi;
		logic [12:0] addr;
	} srap_instr_type;

	// Port configuration bits
	typedef struct packed {
		logic lsb;
		logic asc;
		logic four;
		logic rbsel;
	} srap_cfg_type;

endpackage

// file: srap_port.sv
`timescale 1ns/1ps
`include "srap_cfg.svh"
// Notes on behaviour
// - Frame opens with a 16-bit instruction on sixteen rising edges, then bytes.
// - First instruction bit in MSB order is direction; fifteen address bits follow.
// - Address bits 14 and 13 are ignored; thirteen bits select a register.
// - Write payload bits sampled on rising edges; whole bytes go to buffers or to the port control registers.
// - Buffered values reach active registers only on a transfer operation.
// - Writing one to 0x000F bit 0 triggers the transfer; bit self-clears.
// - An enabled external pin can also trigger the transfer.
// - Reads shift eight bits per byte from the start address onward.
// - Read data changes on falling edges, host captures on rising edges.
// - Multibyte reads return every address in order, blanks included.
// - Readback source is buffer or active, chosen by 0x0001 bit 5.
// - MSB first by default; 0x0000 bit 6 set selects LSB first.
// - Bit order change takes effect immediately for following bits.
// - Address direction bit zero: address decrements after each byte.
// - Address direction bit one: address increments after each byte.
// - Multibyte writes never skip addresses; each byte takes the next.
// - Bytes stream while select is low; select high ends the stream.
// - Three-wire uses one data pin both ways; four-wire adds an output.
// - Both data pins released while select is high.
module srap_port (
	input  wire logic                      CLOCK,
	input  wire logic                      SYS_RST,
	input  wire logic                      SCLK,
	input  wire logic                      CS_N,
	input  wire logic                      SDIO_IN,
	output logic                           SDIO_OUT,
	output logic                           SDIO_OE,
	output logic                           SERIAL_DATA_OUT,
	output logic                           SERIAL_DATA_OUT_OE,
	input  wire logic                      UPDATE_PIN,
	input  wire logic                      UPDATE_PIN_EN,
	input  wire logic [`SRAP_MAP_AW-1:0]   ACT_ADDR,
	output logic      [7:0]                ACT_DATA,
	output logic                           ACT_UPDATED
);

	// Serial clock domain state
	srap_pkg::srap_phase_type  phase;
	logic [3:0]                cnt;
	logic [15:0]               sr;
	logic                      rd;
	logic [12:0]               addr;
	logic [7:0]                rd_byte;
	logic                      out_bit;
	logic                      drv;
	srap_pkg::srap_cfg_type    cfg;
	logic [7:0]                buffer [`SRAP_MAP_DEPTH];
	logic                      upd_tgl;
	logic                      rs1;
	logic                      rs2;

	// System clock domain state
	logic [7:0]                active [`SRAP_MAP_DEPTH];
	logic                      t1;
	logic                      t2;
	logic                      t3;
	logic                      tlvl;
	logic                      p1;
	logic                      p2;
	logic                      p3;
	logic                      plvl;
	logic                      rst_hold;
	logic                      a1;
	logic                      a2;
	logic                      a3;

	// Combinational helpers
	logic [15:0]               next_instr;
	logic [7:0]                next_byte;
	srap_pkg::srap_instr_type  instr;
	logic                      wr_en;
	logic                      upd_sw;
	logic                      upd_pin;
	logic                      update;

	// True when an address falls in the buffered window
	function automatic logic in_map(input logic [12:0] a);
		logic [12:0] top;
		top = `SRAP_MAP_BASE + 13'(`SRAP_MAP_DEPTH);
		return (a >= `SRAP_MAP_BASE) && (a < top);
	endfunction

	// Window index of an address
	function automatic logic [`SRAP_MAP_AW-1:0] map_idx(input logic [12:0] a);
		logic [12:0] d;
		d = a - `SRAP_MAP_BASE;
		return d[`SRAP_MAP_AW-1:0];
	endfunction

	// Next address after a byte, wrapping in thirteen bits
	function automatic logic [12:0] step(input logic [12:0] a,
	                                     input logic        up);
		logic [12:0] n;
		n = up ? a + 13'h0001 : a - 13'h0001;
		return n;
	endfunction

	// Byte presented for a read at an address
	function automatic logic [7:0] read_reg(input logic [12:0] a);
		logic [7:0] v;
		v = `SRAP_RST_BYTE;
		if (a == `SRAP_ADDR_CFG) begin
			v[`SRAP_BIT_LSB]  = cfg.lsb;
			v[`SRAP_BIT_ASC]  = cfg.asc;
			v[`SRAP_BIT_FOUR] = cfg.four;
		end else if (a == `SRAP_ADDR_RBSEL) begin
			v[`SRAP_BIT_RBSEL] = cfg.rbsel;
		end else if (in_map(a)) begin
			v = cfg.rbsel ? active[map_idx(a)] : buffer[map_idx(a)];
		end
		return v;
	endfunction

	// Incoming bit assembled in the selected order
	always_comb begin
		if (cfg.lsb) begin
			next_instr = {SDIO_IN, sr[15:1]};
			next_byte  = {SDIO_IN, sr[7:1]};
		end else begin
			next_instr = {sr[14:0], SDIO_IN};
			next_byte  = {sr[6:0], SDIO_IN};
		end
		instr = next_instr;
	end

	// Completed write byte, only while the frame is open
	assign wr_en = (phase == srap_pkg::SRAP_DATA) && !rd &&
	               (cnt == `SRAP_BYTE_LAST) && !CS_N;

	// Frame sequencer, cleared by select going high
	always_ff @(posedge SCLK or posedge CS_N) begin
		if (CS_N) begin
			phase   <= srap_pkg::SRAP_INSTR;
			cnt     <= 4'h0;
			sr      <= 16'h0000;
			rd      <= 1'b0;
			addr    <= 13'h0000;
			rd_byte <= `SRAP_RST_BYTE;
		end else begin
			unique case (phase)
				srap_pkg::SRAP_INSTR: begin
					sr <= next_instr;
					if (cnt == `SRAP_INSTR_LAST) begin
						phase   <= srap_pkg::SRAP_DATA;
						cnt     <= 4'h0;
						rd      <= instr.rw;
						addr    <= instr.addr;
						rd_byte <= read_reg(instr.addr);
					end else begin
						cnt <= cnt + 4'h1;
					end
				end
				srap_pkg::SRAP_DATA: begin
					sr <= {sr[15:8], next_byte};
					if (cnt == `SRAP_BYTE_LAST) begin
						cnt  <= 4'h0;
						addr <= step(addr, cfg.asc);
						if (rd) begin
							rd_byte <= read_reg(step(addr, cfg.asc));
						end
					end else begin
						cnt <= cnt + 4'h1;
					end
				end
				default: begin
					phase <= srap_pkg::SRAP_INSTR;
					cnt   <= 4'h0;
				end
			endcase
		end
	end

	// Read bit launched on the falling edge
	always_ff @(negedge SCLK or posedge CS_N) begin
		if (CS_N) begin
			out_bit <= 1'b0;
			drv     <= 1'b0;
		end else begin
			drv <= (phase == srap_pkg::SRAP_DATA) && rd;
			if (cfg.lsb) begin
				out_bit <= rd_byte[cnt[2:0]];
			end else begin
				out_bit <= rd_byte[3'h7 - cnt[2:0]];
			end
		end
	end

	// Pin drivers, released whenever select is high
	assign SDIO_OUT           = out_bit;
	assign SERIAL_DATA_OUT    = out_bit;
	assign SDIO_OE            = drv && !CS_N && !cfg.four;
	assign SERIAL_DATA_OUT_OE = drv && !CS_N && cfg.four;

	// Reset request into the serial domain; set at once, so no link
	// edge is needed to see it, and cleared only on link edges
	always_ff @(posedge SCLK or posedge rst_hold) begin
		if (rst_hold) begin
			rs1 <= 1'b1;
			rs2 <= 1'b1;
		end else begin
			rs1 <= 1'b0;
			rs2 <= rs1;
		end
	end

	// Port configuration written over the link
	always_ff @(posedge SCLK) begin
		if (rs2) begin
			cfg.lsb   <= `SRAP_RST_LSB;
			cfg.asc   <= `SRAP_RST_ASC;
			cfg.four  <= `SRAP_RST_FOUR;
			cfg.rbsel <= `SRAP_RST_RBSEL;
		end else if (wr_en && addr == `SRAP_ADDR_CFG) begin
			cfg.lsb  <= next_byte[`SRAP_BIT_LSB];
			cfg.asc  <= next_byte[`SRAP_BIT_ASC];
			cfg.four <= next_byte[`SRAP_BIT_FOUR];
		end else if (wr_en && addr == `SRAP_ADDR_RBSEL) begin
			cfg.rbsel <= next_byte[`SRAP_BIT_RBSEL];
		end
	end

	// Buffer registers, written byte by byte
	always_ff @(posedge SCLK) begin
		if (rs2) begin
			for (int i = 0; i < `SRAP_MAP_DEPTH; i++) begin
				buffer[i] <= `SRAP_RST_BYTE;
			end
		end else if (wr_en && in_map(addr)) begin
			buffer[map_idx(addr)] <= next_byte;
		end
	end

	// Transfer request as a toggle; the bit itself never stores
	// Cleared at once by reset so the crossing settles with the ack
	always_ff @(posedge SCLK or posedge rst_hold) begin
		if (rst_hold) begin
			upd_tgl <= 1'b0;
		end else if (wr_en && addr == `SRAP_ADDR_UPDATE &&
		             next_byte[`SRAP_BIT_UPDATE]) begin
			upd_tgl <= ~upd_tgl;
		end
	end

	// Reset held until the serial domain has seen it
	always_ff @(posedge CLOCK) begin
		a1 <= rs2;
		a2 <= a1;
		a3 <= a2;
		if (SYS_RST) begin
			rst_hold <= 1'b1;
		end else if (a2 && a3) begin
			rst_hold <= 1'b0;
		end
	end

	// Toggle crossing; a change counts once two stages agree
	always_ff @(posedge CLOCK) begin
		t1 <= upd_tgl;
		t2 <= t1;
		t3 <= t2;
		if (SYS_RST || rst_hold || t2 == t3) begin
			tlvl <= t3; // Follows the toggle while reset settles
		end
	end

	assign upd_sw = !rst_hold && (t2 == t3) && (t3 != tlvl);

	// External transfer pin, rising edge after agreement
	always_ff @(posedge CLOCK) begin
		p1 <= UPDATE_PIN;
		p2 <= p1;
		p3 <= p2;
		if (SYS_RST) begin
			plvl <= 1'b0;
		end else if (p2 == p3) begin
			plvl <= p3;
		end
	end

	assign upd_pin = (p2 == p3) && p3 && !plvl && UPDATE_PIN_EN;
	assign update  = upd_sw || upd_pin;

	// Active registers copied from the buffers in one cycle
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			for (int i = 0; i < `SRAP_MAP_DEPTH; i++) begin
				active[i] <= `SRAP_RST_BYTE;
			end
		end else if (update) begin
			for (int i = 0; i < `SRAP_MAP_DEPTH; i++) begin
				active[i] <= buffer[i];
			end
		end
	end

	// Active register view and transfer notice
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			ACT_DATA    <= `SRAP_RST_BYTE;
			ACT_UPDATED <= 1'b0;
		end else begin
			ACT_DATA    <= active[ACT_ADDR];
			ACT_UPDATED <= update;
		end
	end

endmodule

// file: srap_port_properties.sv
`timescale 1ns/1ps
module srap_port_chk (
	input wire logic       CLOCK,
	input wire logic       SYS_RST,
	input wire logic       SCLK,
	input wire logic       CS_N,
	input wire logic       SDIO_IN,
	input wire logic       SDIO_OUT,
	input wire logic       SDIO_OE,
	input wire logic       SERIAL_DATA_OUT,
	input wire logic       SERIAL_DATA_OUT_OE,
	input wire logic       UPDATE_PIN,
	input wire logic       UPDATE_PIN_EN,
	input wire logic [5:0] ACT_ADDR,
	input wire logic [7:0] ACT_DATA,
	input wire logic       ACT_UPDATED
);
	logic [4:0] rises;
	// Link rising edges seen in this frame
	always_ff @(posedge SCLK or posedge CS_N) begin
		if (CS_N) begin
			rises <= 5'h00;
		end else if (rises != 5'h1f) begin
			rises <= rises + 5'h01;
		end
	end
	chk_sdio_idle: assert property (@(posedge CLOCK)
		disable iff (SYS_RST) CS_N |-> !SDIO_OE) else $error("sdio driven");
	chk_sdo_idle: assert property (@(posedge CLOCK)
		disable iff (SYS_RST) CS_N |-> !SERIAL_DATA_OUT_OE)
		else $error("sdo driven");
	chk_one_driver: assert property (@(posedge CLOCK)
		disable iff (SYS_RST) !(SDIO_OE && SERIAL_DATA_OUT_OE))
		else $error("both pins driven");
	chk_same_bit: assert property (@(posedge SCLK) disable iff (CS_N)
		SERIAL_DATA_OUT_OE |-> SERIAL_DATA_OUT == SDIO_OUT)
		else $error("pin copies differ");
	chk_instr_quiet: assert property (@(posedge SCLK) disable iff (CS_N)
		rises < 5'h10 |-> !SDIO_OE && !SERIAL_DATA_OUT_OE)
		else $error("driven in instruction");
	chk_update_pulse: assert property (@(posedge CLOCK)
		disable iff (SYS_RST) ACT_UPDATED |=> !ACT_UPDATED)
		else $error("update pulse long");
	chk_active_hold: assert property (@(posedge CLOCK)
		disable iff (SYS_RST) $stable(ACT_ADDR) && !ACT_UPDATED &&
		!$past(ACT_UPDATED) |=> $stable(ACT_DATA) || ACT_UPDATED)
		else $error("active changed unasked");
	chk_pin_update: assert property (@(posedge CLOCK)
		disable iff (SYS_RST) $rose(UPDATE_PIN) && UPDATE_PIN_EN
		|-> ##[1:8] ACT_UPDATED) else $error("pin update missing");
	cover property (@(posedge CLOCK) ACT_UPDATED);
	cover property (@(posedge CLOCK) SDIO_OE);
	cover property (@(posedge CLOCK) SERIAL_DATA_OUT_OE);
endmodule

// file: srap_host.sv
`timescale 1ns/1ps
module srap_host (
	output logic      sclk,
	output logic      cs_n,
	output logic      sdio,
	input  wire logic sdio_wire,
	input  wire logic serial_data_out,
	input  wire logic sdo_oe
);
	logic [15:0] rd;
	logic        lsb;
	// Deselected with the link clock parked low
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdio = 1'b0;
		lsb = 1'b0;
		rd = 16'h0000;
	end
	// Idle edges so the link side takes the reset
	task automatic park;
		repeat (4) begin
			#6 sclk = 1'b1;
			#6 sclk = 1'b0;
		end
	endtask
	// One frame; nb payload bits, a short count cuts a byte
	task automatic frame(input logic rw, input logic [14:0] a,
		input logic [15:0] wd, input int nb);
		logic [15:0] w;
		int          i;
		int          j;
		int          k;
		w = {rw, a};
		cs_n = 1'b0;
		#6;
		for (i = 0; i < 16 + nb; i++) begin
			j = (i - 16) % 8;
			k = 8 * (1 - (i - 16) / 8) + (lsb ? j : 7 - j);
			if (i < 16) begin
				k = lsb ? i : 15 - i;
			end
			sdio = (rw && i >= 16) ? ~sdio : (i < 16 ? w[k] : wd[k]);
			#3;
			if (rw && i >= 16) begin
				rd[k] = sdo_oe ? serial_data_out : sdio_wire;
			end
			sclk = 1'b1;
			#6 sclk = 1'b0;
			#3;
		end
		cs_n = 1'b1;
		sdio = ~sdio;
		#12;
	endtask
endmodule

// file: test_spi_register_access_port.sv
`timescale 1ns/1ps
module test_spi_register_access_port;
	logic       clock, sys_rst, sclk, cs_n, host_d, sdio_wire;
	logic       sdio_out, sdio_oe, serial_data_out, sdo_oe;
	logic       update_pin, update_pin_en, act_updated;
	logic [5:0] act_addr;
	logic [7:0] act_data;
	int         errors;
	int         comparisons;
	// Shared line: device drives when enabled, host otherwise
	assign sdio_wire = sdio_oe ? sdio_out : host_d;
	srap_port u_srap_port (.CLOCK(clock), .SYS_RST(sys_rst), .SCLK(sclk),
		.CS_N(cs_n), .SDIO_IN(sdio_wire), .SDIO_OUT(sdio_out),
		.SDIO_OE(sdio_oe), .SERIAL_DATA_OUT(serial_data_out),
		.SERIAL_DATA_OUT_OE(sdo_oe), .UPDATE_PIN(update_pin),
		.UPDATE_PIN_EN(update_pin_en), .ACT_ADDR(act_addr),
		.ACT_DATA(act_data), .ACT_UPDATED(act_updated));
	srap_host u_srap_host (.sclk(sclk), .cs_n(cs_n), .sdio(host_d),
		.sdio_wire(sdio_wire), .serial_data_out(serial_data_out), .sdo_oe(sdo_oe));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic final_report;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [15:0] d, int nb);
		u_srap_host.frame(1'b0, a, d, nb);
	endtask
	task automatic rd2(input logic [14:0] a, input logic [15:0] exp);
		u_srap_host.frame(1'b1, a, 16'h0000, 16);
		chk(u_srap_host.rd, exp);
	endtask
	task automatic act(input logic [5:0] idx, input logic [7:0] exp);
		@(negedge clock) act_addr = idx;
		repeat (2) @(negedge clock);
		chk({8'h00, act_data}, {8'h00, exp});
	endtask
	task automatic upd_wait;
		logic seen;
		seen = 1'b0;
		repeat (20) @(negedge clock) if (act_updated === 1'b1) seen = 1'b1;
		chk({15'h0000, seen}, 16'h0001);
	endtask
	// Reset state of config and active copy
	task automatic t_defaults;
		rd2(15'h0000, 16'h0000);
		act(6'h00, 8'h00);
		wr(15'h0051, 16'h0000, 16);
		rd2(15'h0051, 16'h0000);
	endtask
	// Descending two-byte write, ignored top address bits set
	task automatic t_stream;
		wr(15'h6011, 16'ha1b2, 16);
		rd2(15'h0011, 16'ha1b2);
		act(6'h01, 8'h00);
	endtask
	// Register transfer, self clear, readback source
	task automatic t_update;
		wr(15'h000f, 16'h0100, 8);
		upd_wait();
		act(6'h01, 8'ha1);
		act(6'h00, 8'hb2);
		rd2(15'h000f, 16'h0000);
		wr(15'h0010, 16'h5500, 8);
		wr(15'h0001, 16'h2000, 8);
		rd2(15'h0010, 16'hb200);
		wr(15'h0001, 16'h0000, 8);
		rd2(15'h0010, 16'h5500);
	endtask
	// LSB first, ascending, four-wire readback
	task automatic t_modes;
		wr(15'h0000, 16'h7000, 8);
		u_srap_host.lsb = 1'b1;
		wr(15'h0012, 16'hc3d4, 16);
		rd2(15'h0012, 16'hc3d4);
	endtask
	// Select rising inside a byte drops it
	task automatic t_abort;
		wr(15'h0012, 16'h0f0f, 5);
		rd2(15'h0012, 16'hc3d4);
	endtask
	// External pin copies buffers to active
	task automatic t_pin;
		@(negedge clock) update_pin_en = 1'b1;
		@(negedge clock) update_pin = 1'b1;
		upd_wait();
		act(6'h02, 8'hc3);
		@(negedge clock) update_pin = 1'b0;
	endtask
	// Mid-run reset returns port, buffers and active copy to defaults
	task automatic t_reset;
		@(negedge clock) sys_rst = 1'b1;
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		u_srap_host.lsb = 1'b0;
		u_srap_host.park();
		repeat (8) @(negedge clock);
		act(6'h02, 8'h00);
		rd2(15'h0000, 16'h0000);
		rd2(15'h0012, 16'h0000);
	endtask
	initial begin
		errors = 0;
		comparisons = 0;
		sys_rst = 1'b1;
		update_pin = 1'b0;
		update_pin_en = 1'b0;
		act_addr = 6'h00;
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		u_srap_host.park();
		repeat (8) @(negedge clock);
		t_defaults();
		t_stream();
		t_update();
		t_modes();
		t_abort();
		t_pin();
		t_reset();
		final_report();
	end
	// Hang guard
	initial begin
		#100000;
		errors++;
		final_report();
	end
endmodule
bind srap_port srap_port_chk u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
	.SCLK(SCLK), .CS_N(CS_N), .SDIO_IN(SDIO_IN), .SDIO_OUT(SDIO_OUT),
	.SDIO_OE(SDIO_OE), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
	.SERIAL_DATA_OUT_OE(SERIAL_DATA_OUT_OE), .UPDATE_PIN(UPDATE_PIN),
	.UPDATE_PIN_EN(UPDATE_PIN_EN), .ACT_ADDR(ACT_ADDR),
	.ACT_DATA(ACT_DATA), .ACT_UPDATED(ACT_UPDATED));
